// File: line_meas_defines.svh
// offsets, field positions, reset values and widths of the readout block
`ifndef LINE_MEAS_DEFINES_SVH
`define LINE_MEAS_DEFINES_SVH

// register indices; byte address is four times the index
`define IDX_POWER_SELECT   8'h4C
`define IDX_POWER_READING  8'h4D
`define IDX_LOOP_VOLTAGE   8'h4E
`define IDX_LOOP_CURRENT   8'h4F
`define IDX_TIP_VOLTAGE    8'h50
`define IDX_RING_VOLTAGE   8'h51
`define IDX_BATTERY_FIRST  8'h52
`define IDX_BATTERY_SECOND 8'h53
`define IDX_Q1_CURRENT     8'h54
`define IDX_FEED_CONTROL   8'h60

// field positions
`define SIGN_BIT           6
`define MAG_MSB            5
`define FEED_ENABLE_BIT    0

// widths and counts
`define MEAS_W             8
`define MAG_W              6
`define SEL_W              3
`define NUM_TRANSISTORS    6

// reset values
`define MEAS_RESET         8'h00
`define SELECT_RESET       3'h0
`define FEED_RESET         1'b0
`define READ_ZERO          32'h0000_0000

`endif

// File: line_meas_pkg.sv
// types shared by the readout block
package line_meas_pkg;
    // one 8-bit measurement code
    typedef logic [7:0] meas_byte_t;
    // bus handshake state
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_RESP = 1'b1
    } bus_state_e;
endpackage : line_meas_pkg

// File: reg_access_if.sv
// carrier between the bus slave and the register core
`timescale 1ns/10ps
interface reg_access_if;
    logic       wr_stb;   // one-cycle write strobe
    logic [7:0] idx;      // register index
    logic [7:0] wdata;    // write data low byte
    logic       wr_lane0; // byte lane 0 enabled
    logic [7:0] rdata;    // decoded read value
    modport slave (output wr_stb, output idx, output wdata,
                   output wr_lane0, input rdata);
    modport core  (input wr_stb, input idx, input wdata,
                   input wr_lane0, output rdata);
endinterface : reg_access_if

// File: power_sampler.sv
// per-transistor power sampling and selection
`timescale 1ns/10ps
`include "line_meas_defines.svh"
module power_sampler (
    input  wire logic                          i_mclk,
    input  wire logic                          i_rst,
    input  wire logic [`NUM_TRANSISTORS*8-1:0] i_power_raw,
    input  wire logic [`SEL_W-1:0]             i_select,
    output logic [7:0]                         o_power,
    output logic                               o_low_range
);
    // sampled power code per transistor
    logic [7:0] power_r [`NUM_TRANSISTORS];
    // selected code, zero for undefined selects
    logic [7:0] power_nxt;
    wire        sel_valid = (i_select < 3'h6);

    genvar g;
    generate
        for (g = 0; g < `NUM_TRANSISTORS; g++) begin : g_ch
            always_ff @(posedge i_mclk) begin
                if (i_rst) begin
                    power_r[g] <= `MEAS_RESET;
                end else begin
                    power_r[g] <= i_power_raw[g*8 +: 8];
                end
            end
        end
    endgenerate

    assign power_nxt = sel_valid ? power_r[i_select] : `MEAS_RESET;
    // transistors three and four use fine scale
    assign o_low_range = (i_select == 3'h2) || (i_select == 3'h3);

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_power <= `MEAS_RESET;
        end else begin
            o_power <= power_nxt;
        end
    end
endmodule : power_sampler

// File: avmm_slave.sv
// avalon-mm slave handshake with one wait cycle
`timescale 1ns/10ps
module avmm_slave (
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    input  wire logic [9:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    reg_access_if.slave      bus
);
    // handshake state
    line_meas_pkg::bus_state_e state_r;
    wire req = i_avs_read | i_avs_write;

    // word index from byte address, low lane only
    assign bus.idx      = i_avs_address[9:2];
    assign bus.wdata    = i_avs_writedata[7:0];
    assign bus.wr_lane0 = i_avs_byteenable[0];
    // write lands on the edge that sees waitrequest low
    assign bus.wr_stb   = (state_r == line_meas_pkg::BUS_RESP)
                          & i_avs_write;
    // held high until the answer cycle
    assign o_avs_waitrequest = req & (state_r != line_meas_pkg::BUS_RESP);

    // one idle, one answer cycle per access
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state_r <= line_meas_pkg::BUS_IDLE;
        end else begin
            case (state_r)
                line_meas_pkg::BUS_IDLE: begin
                    if (req) begin
                        state_r <= line_meas_pkg::BUS_RESP;
                    end
                end
                default: begin
                    state_r <= line_meas_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    // read data captured before the answer cycle
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (state_r == line_meas_pkg::BUS_IDLE && i_avs_read) begin
            o_avs_readdata <= {24'h00_0000, bus.rdata};
        end
    end
endmodule : avmm_slave

// File: line_measurement_readout.sv
// line measurement readout registers behind an avalon-mm slave
`timescale 1ns/10ps
`include "line_meas_defines.svh"
module line_measurement_readout (
    input  wire logic                          i_mclk,
    input  wire logic                          i_rst,
    // avalon-mm slave
    input  wire logic [9:0]                    i_avs_address,
    input  wire logic                          i_avs_read,
    input  wire logic                          i_avs_write,
    input  wire logic [31:0]                   i_avs_writedata,
    input  wire logic [3:0]                    i_avs_byteenable,
    output logic [31:0]                        o_avs_readdata,
    output logic                               o_avs_waitrequest,
    // analog front end codes
    input  wire logic [`NUM_TRANSISTORS*8-1:0] i_power_raw,
    input  wire logic                          i_loop_voltage_sign,
    input  wire logic [`MAG_W-1:0]             i_loop_voltage_magnitude,
    input  wire logic                          i_loop_current_sign,
    input  wire logic [`MAG_W-1:0]             i_loop_current_magnitude,
    input  wire logic [7:0]                    i_tip_voltage_reading,
    input  wire logic [7:0]                    i_ring_voltage_reading,
    input  wire logic [7:0]                    i_battery_reading_first,
    input  wire logic [7:0]                    i_battery_reading_second,
    input  wire logic [7:0]                    i_q1_current_total,
    input  wire logic [7:0]                    i_extended_feed_offset,
    // control seen by the front end
    output logic                               o_extended_feed_enable,
    output logic                               o_power_low_range
);
    // carrier to the bus slave
    reg_access_if acc ();

    // software-written control
    logic [`SEL_W-1:0] power_monitor_select_r; // transistor pointer
    logic              extended_feed_enable_r; // extra feed on

    // sampled measurement registers
    line_meas_pkg::meas_byte_t selected_power_reading;
    line_meas_pkg::meas_byte_t loop_voltage_r;
    line_meas_pkg::meas_byte_t loop_current_r;
    line_meas_pkg::meas_byte_t tip_voltage_r;
    line_meas_pkg::meas_byte_t ring_voltage_r;
    line_meas_pkg::meas_byte_t battery_first_r;
    line_meas_pkg::meas_byte_t battery_second_r;
    line_meas_pkg::meas_byte_t q1_current_r;

    // next values
    line_meas_pkg::meas_byte_t loop_voltage_nxt;
    line_meas_pkg::meas_byte_t loop_current_nxt;
    line_meas_pkg::meas_byte_t q1_current_nxt;

    // bus handshake
    avmm_slave u_slave (
        .i_mclk            (i_mclk),
        .i_rst             (i_rst),
        .i_avs_address     (i_avs_address),
        .i_avs_read        (i_avs_read),
        .i_avs_write       (i_avs_write),
        .i_avs_writedata   (i_avs_writedata),
        .i_avs_byteenable  (i_avs_byteenable),
        .o_avs_readdata    (o_avs_readdata),
        .o_avs_waitrequest (o_avs_waitrequest),
        .bus               (acc.slave)
    );

    // power channels and pointer mux
    power_sampler u_power (
        .i_mclk      (i_mclk),
        .i_rst       (i_rst),
        .i_power_raw (i_power_raw),
        .i_select    (power_monitor_select_r),
        .o_power     (selected_power_reading),
        .o_low_range (o_power_low_range)
    );

    // write decode: only the two control words accept data
    wire wr_ok      = acc.wr_stb & acc.wr_lane0;
    wire wr_select  = wr_ok & (acc.idx == `IDX_POWER_SELECT);
    wire wr_feed    = wr_ok & (acc.idx == `IDX_FEED_CONTROL);

    // pointer and feed enable registers
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            power_monitor_select_r <= `SELECT_RESET;
            extended_feed_enable_r <= `FEED_RESET;
        end else begin
            if (wr_select) begin
                power_monitor_select_r <= acc.wdata[`SEL_W-1:0];
            end
            if (wr_feed) begin
                extended_feed_enable_r <= acc.wdata[`FEED_ENABLE_BIT];
            end
        end
    end
    assign o_extended_feed_enable = extended_feed_enable_r;

    // sign in bit 6, bit 7 zero
    assign loop_voltage_nxt = {1'b0, i_loop_voltage_sign,
                               i_loop_voltage_magnitude};
    assign loop_current_nxt = {1'b0, i_loop_current_sign,
                               i_loop_current_magnitude};

    // subtract the extra feed, floor at zero
    wire q1_under = i_extended_feed_offset > i_q1_current_total;
    wire [7:0] q1_less = i_q1_current_total - i_extended_feed_offset;
    assign q1_current_nxt = !extended_feed_enable_r ? i_q1_current_total :
                            q1_under ? `MEAS_RESET : q1_less;

    // refresh every cycle, bus writes never reach here
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            loop_voltage_r   <= `MEAS_RESET;
            loop_current_r   <= `MEAS_RESET;
            tip_voltage_r    <= `MEAS_RESET;
            ring_voltage_r   <= `MEAS_RESET;
            battery_first_r  <= `MEAS_RESET;
            battery_second_r <= `MEAS_RESET;
            q1_current_r     <= `MEAS_RESET;
        end else begin
            loop_voltage_r   <= loop_voltage_nxt;
            loop_current_r   <= loop_current_nxt;
            tip_voltage_r    <= i_tip_voltage_reading;
            ring_voltage_r   <= i_ring_voltage_reading;
            battery_first_r  <= i_battery_reading_first;
            battery_second_r <= i_battery_reading_second;
            q1_current_r     <= q1_current_nxt;
        end
    end

    // read decode; unmapped words read zero
    // code reported as is, scale set by pointer
    assign acc.rdata =
        (acc.idx == `IDX_POWER_SELECT)   ? {5'h00, power_monitor_select_r} :
        (acc.idx == `IDX_POWER_READING)  ? selected_power_reading :
        (acc.idx == `IDX_LOOP_VOLTAGE)   ? loop_voltage_r :
        (acc.idx == `IDX_LOOP_CURRENT)   ? loop_current_r :
        (acc.idx == `IDX_TIP_VOLTAGE)    ? tip_voltage_r :
        (acc.idx == `IDX_RING_VOLTAGE)   ? ring_voltage_r :
        (acc.idx == `IDX_BATTERY_FIRST)  ? battery_first_r :
        (acc.idx == `IDX_BATTERY_SECOND) ? battery_second_r :
        (acc.idx == `IDX_Q1_CURRENT)     ? q1_current_r :
        (acc.idx == `IDX_FEED_CONTROL)   ? {7'h00, extended_feed_enable_r} :
                                           8'h00;
endmodule : line_measurement_readout

// File: line_measurement_readout_props.sv
// assertions on the readout block ports
`timescale 1ns/10ps
`include "line_meas_defines.svh"
module line_measurement_readout_props (
    input wire logic              i_mclk,
    input wire logic              i_rst,
    input wire logic [9:0]        i_avs_address,
    input wire logic              i_avs_read,
    input wire logic              i_avs_write,
    input wire logic [31:0]       o_avs_readdata,
    input wire logic              o_avs_waitrequest,
    input wire logic              i_loop_voltage_sign,
    input wire logic [`MAG_W-1:0] i_loop_voltage_magnitude,
    input wire logic              i_loop_current_sign,
    input wire logic [`MAG_W-1:0] i_loop_current_magnitude,
    input wire logic [7:0]        i_tip_voltage_reading,
    input wire logic [7:0]        i_q1_current_total,
    input wire logic [7:0]        i_extended_feed_offset,
    input wire logic              o_extended_feed_enable,
    input wire logic              o_power_low_range
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    wire [7:0] idx = i_avs_address[9:2]; // word index
    // writes that may move the pointer or the feed bit
    wire wr_sel = i_avs_write && !o_avs_waitrequest && idx == 8'h4C;
    wire wr_feed = i_avs_write && !o_avs_waitrequest && idx == 8'h60;
    // reading with the extended feed share removed, floored at zero
    wire [7:0] q1_exp = !o_extended_feed_enable ? i_q1_current_total
        : i_q1_current_total > i_extended_feed_offset
        ? i_q1_current_total - i_extended_feed_offset : 8'h00;
    // a request still waiting
    sequence s_req_wait;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence
    // read answer; reset-time captures are excluded since they read zero
    sequence s_rd(r);
        i_avs_read && !o_avs_waitrequest && idx == r && !$past(i_rst, 2);
    endsequence
    a_one_wait: assert property (s_req_wait |=> !o_avs_waitrequest)
        else $error("answer missing after one wait cycle");
    a_upper_zero: assert property (o_avs_readdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    a_loop_volt: assert property (s_rd(8'h4E) |-> o_avs_readdata[7:0] ==
        {1'h0, $past(i_loop_voltage_sign, 2),
        $past(i_loop_voltage_magnitude, 2)})
        else $error("loop voltage reading wrong");
    a_loop_curr: assert property (s_rd(8'h4F) |-> o_avs_readdata[7:0] ==
        {1'h0, $past(i_loop_current_sign, 2),
        $past(i_loop_current_magnitude, 2)})
        else $error("loop current reading wrong");
    a_tip_read: assert property (s_rd(8'h50) |->
        o_avs_readdata[7:0] == $past(i_tip_voltage_reading, 2))
        else $error("tip reading wrong");
    a_q1_read: assert property (s_rd(8'h54) |->
        o_avs_readdata[7:0] == $past(q1_exp, 2))
        else $error("transistor one reading wrong");
    a_unmapped_zero: assert property (s_rd(8'hFF) |->
        o_avs_readdata == 32'h00000000)
        else $error("unmapped read not zero");
    a_range_hold: assert property (!wr_sel |=> $stable(o_power_low_range))
        else $error("range flag moved without pointer write");
    a_feed_hold: assert property (!wr_feed && !$past(wr_feed) |=>
        $stable(o_extended_feed_enable))
        else $error("feed enable moved without write");
endmodule : line_measurement_readout_props
bind line_measurement_readout line_measurement_readout_props u_props (
    .i_mclk, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write,
    .o_avs_readdata, .o_avs_waitrequest, .i_loop_voltage_sign,
    .i_loop_voltage_magnitude, .i_loop_current_sign,
    .i_loop_current_magnitude, .i_tip_voltage_reading,
    .i_q1_current_total, .i_extended_feed_offset,
    .o_extended_feed_enable, .o_power_low_range);

// File: line_measurement_readout_bench.sv
// self-checking bench for the readout block
`timescale 1ns/10ps
module line_measurement_readout_bench;
    logic        mclk = 1'h0;  // 25 MHz clock
    logic        rst = 1'h1;   // sync reset
    logic [9:0]  addr = 10'h000;
    logic        rd = 1'h0;
    logic        wr = 1'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  be = 4'hF;
    logic [31:0] rdata;
    logic        waitreq;
    logic        feed_en;
    logic        low_rng;
    logic [47:0] pwr = 48'h0;
    logic        vs = 1'h1;    // nonzero so reset clear shows
    logic        cs = 1'h1;
    logic [5:0]  vm = 6'h15;
    logic [5:0]  cm = 6'h2A;
    logic [7:0]  tip = 8'h11;
    logic [7:0]  ring = 8'h22;
    logic [7:0]  b1 = 8'h33;
    logic [7:0]  b2 = 8'h44;
    logic [7:0]  q1 = 8'h55;
    logic [7:0]  off = 8'h00;
    logic [2:0]  sel;
    logic [31:0] r;
    logic [31:0] seed = 32'h0001211A; // xorshift state
    logic [31:0] q[$];                // expected read data
    int          bad_count = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    initial forever #20 mclk = ~mclk;
    line_measurement_readout dut (.i_mclk(mclk), .i_rst(rst),
        .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdata), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
        .i_power_raw(pwr), .i_loop_voltage_sign(vs),
        .i_loop_voltage_magnitude(vm), .i_loop_current_sign(cs),
        .i_loop_current_magnitude(cm), .i_tip_voltage_reading(tip),
        .i_ring_voltage_reading(ring), .i_battery_reading_first(b1),
        .i_battery_reading_second(b2), .i_q1_current_total(q1),
        .i_extended_feed_offset(off), .o_extended_feed_enable(feed_en),
        .o_power_low_range(low_rng));
    // xorshift step
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    // one bus cycle, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] i,
                       input logic [7:0] d, input logic [3:0] b);
        rd <= !w;
        wr <= w;
        addr <= {i, 2'h0};
        wdata <= {24'h0, d};
        be <= b;
        // held until a rising edge samples waitrequest low
        do @(posedge mclk); while (waitreq !== 1'h0);
    endtask : bus
    task automatic rdx(input logic [7:0] i, input logic [7:0] e);
        q.push_back({24'h0, e});
        bus(1'h0, i, 8'h00, 4'hF);
    endtask : rdx
    // release the bus for a cycle
    task automatic idle();
        rd <= 1'h0;
        wr <= 1'h0;
        @(posedge mclk);
    endtask : idle
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out
    // read answers checked at the accepting edge, oldest note first
    always @(posedge mclk) begin
        if (rd && waitreq === 1'h0)
            chk(q.pop_front(), rdata);
    end
    // hang guard, far above the roughly 540 cycles needed
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 4000) begin
            bad_count++;
            close_out();
        end
    end
    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'h0;
        rdx(8'h4E, 8'h00);
        for (int n = 0; n < 16; n++) begin
            sel = n[2:0];
            bus(1'h1, 8'h4C, {5'h0, sel}, 4'hF);
            bus(1'h1, 8'h60, {7'h0, n[3]}, 4'hF);
            idle();
            r = rnd();
            {vs, vm, cs, cm} <= r[13:0];
            {tip, ring} <= r[31:16];
            r = rnd();
            {b1, b2, q1, off} <= r;
            pwr <= {rnd(), r[15:0]};
            @(posedge mclk);
            chk({31'h0, sel == 3'h2 || sel == 3'h3}, {31'h0, low_rng});
            chk({31'h0, n[3]}, {31'h0, feed_en});
            bus(1'h1, 8'h4C, 8'h07, 4'h0);
            rdx(8'h4C, {5'h0, sel});
            rdx(8'h4D, sel < 3'h6 ? pwr[sel*8 +: 8] : 8'h00);
            rdx(8'h4E, {1'h0, vs, vm});
            rdx(8'h4F, {1'h0, cs, cm});
            rdx(8'h50, tip);
            rdx(8'h51, ring);
            rdx(8'h52, b1);
            rdx(8'h53, b2);
            rdx(8'h54, n[3] ? (q1 > off ? q1 - off : 8'h00) : q1);
            bus(1'h1, 8'h4F, 8'hFF, 4'hF);
            rdx(8'h4F, {1'h0, cs, cm});
            rdx(8'hFF, 8'h00);
            idle();
            $display("pass %0d done", n);
        end
        close_out();
    end
endmodule : line_measurement_readout_bench
